// ===== src/bpc_comparators.sv
`timescale 1ns/1ps
`default_nettype none
`include "bpc_params.svh"
module bpc_comparators (
  input  wire logic                   sys_clk_in,      // core bus clock
  input  wire logic                   reset_n_in,      // async reset, low
  input  wire logic [`BPC_ADDR_W-1:0] reg_addr_in,     // register address
  input  wire logic [7:0]             reg_wdata_in,    // write data
  input  wire logic                   reg_wr_in,       // write strobe
  input  wire logic                   reg_rd_in,       // read strobe
  input  wire logic [15:0]            core_addr_bus_in,     // cpu address
  input  wire logic [21:14]           expanded_addr_bus_in, // expanded addr
  input  wire logic                   flash_access_in, // access in flash/rom
  input  wire logic [15:0]            data_bus_in,     // core data bus
  input  wire logic                   read_cycle_in,   // 1 read, 0 write
  input  wire logic                   bus_valid_in,    // bus cycle strobe
  output logic [7:0]                  reg_rdata_out,   // read data
  output logic                        match_a_out,     // comparator a hit
  output logic                        match_b_out,     // comparator b hit
  output logic                        irq_out          // interrupt level
);
  import bpc_pkg::*;

  bpc_state_t s_r;
  bpc_state_t s_nxt;

  ////////////////////////////////////////////////////////////////////////////
  function automatic bpc_mask_t mask_decode(input logic hi, input logic lo);
    // 1:0 makes no sense and is forced to a full compare
    if (!lo) begin
      return BPC_MSK_FULL;
    end else if (!hi) begin
      return BPC_MSK_256;
    end else begin
      return BPC_MSK_16K;
    end
  endfunction : mask_decode

  // address compare shared by comparators a and b
  function automatic logic addr_match(input logic [7:0] ext,
                                      input logic [7:0] hi,
                                      input logic [7:0] lo,
                                      input bpc_mask_t  msk,
                                      input logic       trace,
                                      input logic [15:0] ab,
                                      input logic [21:14] expanded_addr_bus,
                                      input logic       flash);
    logic       use_ext;
    logic       ext_ok;
    logic       hi_ok;
    logic       lo_ok;
    logic [7:0] hi_bus;
    use_ext = 1'b0;
    ext_ok  = 1'b1;
    hi_bus  = ab[15:8];
    if (trace) begin
      // selector bit 7 ignored: 10/11 alias 00/01
      if (ext[`BPC_SEL_L] == `BPC_SEL_PROG) begin
        use_ext = 1'b1;
        ext_ok  = (ext[5:0] == expanded_addr_bus[21:16]);
        hi_bus  = {expanded_addr_bus[15:14], ab[13:8]};
      end
    end else if (flash) begin
      // page selector has no meaning here
      use_ext = 1'b1;
      ext_ok  = (ext[5:0] == expanded_addr_bus[19:14]);
      hi_bus  = {hi[7:6], ab[13:8]};
    end
    if (!use_ext) begin
      ext_ok = 1'b1;
    end
    hi_ok = (hi == hi_bus);
    lo_ok = (lo == ab[7:0]);
    unique case (msk)
      BPC_MSK_FULL: return ext_ok && hi_ok && lo_ok;
      BPC_MSK_256:  return ext_ok && hi_ok;
      BPC_MSK_16K:  return ext_ok;
    endcase
    return 1'b0;
  endfunction : addr_match

  function automatic logic dir_ok(input logic en, input logic val,
                                  input logic rd);
    // value 0 matches writes, 1 matches reads
    return !en || (val == rd);
  endfunction : dir_ok

  ////////////////////////////////////////////////////////////////////////////
  logic       full_mode;
  logic       tag_mode;
  logic       trace_mode_enable;
  logic       hit_a;
  logic       hit_b;
  logic       data_hi_ok;
  logic       data_lo_ok;
  logic [1:0] events;
  logic [7:0] rd_val;

  always_comb begin
    full_mode         = s_r.ctl2_r[`BPC_C2_FULL];
    tag_mode          = s_r.ctl2_r[`BPC_C2_TAG];
    trace_mode_enable = s_r.ctl2_r[`BPC_C2_TRACE];
    hit_a = addr_match(s_r.a_ext_r, s_r.a_hi_r, s_r.a_lo_r,
                       mask_decode(s_r.ctl3_r[`BPC_C3_AMH],
                                   s_r.ctl3_r[`BPC_C3_AML]),
                       trace_mode_enable, core_addr_bus_in,
                       expanded_addr_bus_in, flash_access_in)
            && (tag_mode || dir_ok(s_r.ctl3_r[`BPC_C3_ADQ],
                                   s_r.ctl3_r[`BPC_C3_ADV],
                                   read_cycle_in));
    // data masks: bit set drops that byte; extended bits unused in full
    data_hi_ok = s_r.ctl3_r[`BPC_C3_BMH]
                 || (s_r.b_hi_r == data_bus_in[15:8]);
    data_lo_ok = s_r.ctl3_r[`BPC_C3_BML]
                 || (s_r.b_lo_r == data_bus_in[7:0]);
    if (full_mode) begin
      // direction of b ignored; tagging drops data compare
      hit_b = hit_a && (tag_mode
                        || (data_hi_ok && data_lo_ok));
    end else begin
      hit_b = addr_match(s_r.b_ext_r, s_r.b_hi_r, s_r.b_lo_r,
                         mask_decode(s_r.ctl3_r[`BPC_C3_BMH],
                                     s_r.ctl3_r[`BPC_C3_BML]),
                         trace_mode_enable, core_addr_bus_in,
                         expanded_addr_bus_in, flash_access_in)
              && (tag_mode || dir_ok(s_r.ctl3_r[`BPC_C3_BDQ],
                                     s_r.ctl3_r[`BPC_C3_BDV],
                                     read_cycle_in));
    end
    // in full mode only the combined hit counts as a breakpoint
    hit_a = hit_a && bus_valid_in && !full_mode;
    hit_b = hit_b && bus_valid_in;
    events = {hit_b, hit_a};

    unique case (reg_addr_in)
      `BPC_OFS_CTL3:  rd_val = s_r.ctl3_r;
      `BPC_OFS_CTL2:  rd_val = s_r.ctl2_r;
      `BPC_OFS_A_EXT: rd_val = s_r.a_ext_r;
      `BPC_OFS_A_HI:  rd_val = s_r.a_hi_r;
      `BPC_OFS_A_LO:  rd_val = s_r.a_lo_r;
      `BPC_OFS_B_EXT: rd_val = s_r.b_ext_r;
      `BPC_OFS_B_HI:  rd_val = s_r.b_hi_r;
      `BPC_OFS_B_LO:  rd_val = s_r.b_lo_r;
      `BPC_OFS_STAT:  rd_val = {6'h00, s_r.stat_r};
      `BPC_OFS_MASK:  rd_val = {6'h00, s_r.mask_r};
      default:        rd_val = `BPC_RST_BYTE;
    endcase

    s_nxt           = s_r;
    s_nxt.match_a_r = hit_a;
    s_nxt.match_b_r = hit_b;
    s_nxt.rdata_r   = reg_rd_in ? rd_val : `BPC_RST_BYTE;
    // a new event wins over a write-one clear in the same cycle
    s_nxt.stat_r    = (s_r.stat_r
                       & ~((reg_wr_in && reg_addr_in == `BPC_OFS_STAT)
                           ? reg_wdata_in[1:0] : 2'h0)) | events;
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        `BPC_OFS_CTL3:  s_nxt.ctl3_r  = reg_wdata_in;
        `BPC_OFS_CTL2:  s_nxt.ctl2_r  = {5'h00, reg_wdata_in[2:0]};
        `BPC_OFS_A_EXT: s_nxt.a_ext_r = reg_wdata_in;
        `BPC_OFS_A_HI:  s_nxt.a_hi_r  = reg_wdata_in;
        `BPC_OFS_A_LO:  s_nxt.a_lo_r  = reg_wdata_in;
        `BPC_OFS_B_EXT: s_nxt.b_ext_r = reg_wdata_in;
        `BPC_OFS_B_HI:  s_nxt.b_hi_r  = reg_wdata_in;
        `BPC_OFS_B_LO:  s_nxt.b_lo_r  = reg_wdata_in;
        `BPC_OFS_MASK:  s_nxt.mask_r  = reg_wdata_in[1:0];
        default:        s_nxt.ctl3_r  = s_r.ctl3_r;
      endcase
    end
    s_nxt.irq_r = |(s_nxt.stat_r & s_nxt.mask_r);
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata_out = s_r.rdata_r;
  assign match_a_out   = s_r.match_a_r;
  assign match_b_out   = s_r.match_b_r;
  assign irq_out       = s_r.irq_r;
endmodule : bpc_comparators
`default_nettype wire

// ===== src/bpc_params.svh
// Overview of operation
// - comparator B direction qualifier enable 0 ignores direction, 1 uses it in dual mode outside tag mode
// - with qualifier on, direction bit 0 matches writes, 1 matches reads
// - full mode: comparator B direction bits have no effect
// - comparator A mask x:0 full, 0:1 256-byte, 1:1 16K-byte range
// - dual mode: comparator B uses the same three address mask encodings
// - 256-byte range compares extended bits and high byte only
// - 16K-byte range compares only extended page bits
// - extended bits join an address match on flash in breakpoint mode, and in trace mode only when program page selected
// - full mode B masks: 0:0 both, 0:1 high, 1:0 low, 1:1 none
// - full mode: comparator B extended bits never participate
// - trace mode: page selector bit 7 ignored, 10/11 act as 00/01
// - breakpoint mode: selector ignored, extended vs expanded 19:14 on flash
// - breakpoint mode: non-flash high vs 15:8, flash high 5:0 vs 13:8
// - trace selector 01: extended vs 21:16, high vs expanded 15:14 and 13:8
// - each compare value bit must equal its address bus bit under mask
// - extended bits compared to page signals per mode and selector
// - full mode needs address A and data B match; tagging ignores data
`ifndef BPC_PARAMS_SVH
`define BPC_PARAMS_SVH
`define BPC_ADDR_W        6
`define BPC_OFS_CTL3      6'h28
`define BPC_OFS_CTL2      6'h29
`define BPC_OFS_A_EXT     6'h2a
`define BPC_OFS_A_HI      6'h2b
`define BPC_OFS_A_LO      6'h2c
`define BPC_OFS_B_EXT     6'h2d
`define BPC_OFS_B_HI      6'h2e
`define BPC_OFS_B_LO      6'h2f
`define BPC_OFS_STAT      6'h30
`define BPC_OFS_MASK      6'h31
`define BPC_RST_BYTE      8'h00
`define BPC_SEL_B         7
`define BPC_SEL_L         6
`define BPC_SEL_PROG      1'b1
`define BPC_C3_AMH        7
`define BPC_C3_AML        6
`define BPC_C3_BMH        5
`define BPC_C3_BML        4
`define BPC_C3_ADQ        3
`define BPC_C3_ADV        2
`define BPC_C3_BDQ        1
`define BPC_C3_BDV        0
`define BPC_C2_FULL       0
`define BPC_C2_TAG        1
`define BPC_C2_TRACE      2
`define BPC_ST_A          0
`define BPC_ST_B          1
`endif

// ===== src/bpc_pkg.sv
package bpc_pkg;
  typedef enum logic [1:0] {
    BPC_MSK_FULL,
    BPC_MSK_256,
    BPC_MSK_16K
  } bpc_mask_t;
  typedef struct packed {
    logic [7:0] ctl3_r;
    logic [7:0] ctl2_r;
    logic [7:0] a_ext_r;
    logic [7:0] a_hi_r;
    logic [7:0] a_lo_r;
    logic [7:0] b_ext_r;
    logic [7:0] b_hi_r;
    logic [7:0] b_lo_r;
    logic [1:0] stat_r;
    logic [1:0] mask_r;
    logic [7:0] rdata_r;
    logic       match_a_r;
    logic       match_b_r;
    logic       irq_r;
  } bpc_state_t;
endpackage : bpc_pkg

// ===== tb/bpc_props_properties.sv
`timescale 1ns/1ps
`default_nettype none
module bpc_props (
  input wire logic       sys_clk_in,    // clock
  input wire logic       reset_n_in,    // reset
  input wire logic [5:0] reg_addr_in,   // reg address
  input wire logic [7:0] reg_wdata_in,  // write data
  input wire logic       reg_wr_in,     // write
  input wire logic       reg_rd_in,     // read
  input wire logic       read_cycle_in, // bus direction
  input wire logic       bus_valid_in,  // bus cycle
  input wire logic [7:0] reg_rdata_out, // read data
  input wire logic       match_a_out,   // hit a
  input wire logic       match_b_out,   // hit b
  input wire logic       irq_out        // interrupt
);
  logic [7:0] c2_r;
  logic [7:0] c3_r;
  logic [1:0] msk_r;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  // shadows of the mode registers, rebuilt from observed writes
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      c2_r  <= 8'h00;
      c3_r  <= 8'h00;
      msk_r <= 2'h0;
    end else if (reg_wr_in) begin
      if (reg_addr_in == 6'h29) c2_r <= {5'h00, reg_wdata_in[2:0]};
      if (reg_addr_in == 6'h28) c3_r <= reg_wdata_in;
      if (reg_addr_in == 6'h31) msk_r <= reg_wdata_in[1:0];
    end
  end
  idle_a_a: assert property (!bus_valid_in |=> !match_a_out)
    else $error("match a without bus cycle");
  idle_b_a: assert property (!bus_valid_in |=> !match_b_out)
    else $error("match b without bus cycle");
  full_no_a_a: assert property (c2_r[0] |=> !match_a_out)
    else $error("comparator a reported alone in full mode");
  dir_b_a: assert property (bus_valid_in && c2_r == 8'h00 && c3_r[1]
    && read_cycle_in != c3_r[0] |=> !match_b_out)
    else $error("comparator b ignored bus direction");
  mask_irq_a: assert property (msk_r == 2'h0 && $past(msk_r) == 2'h0
    |-> !irq_out) else $error("irq with all sources masked");
  hit_irq_a: assert property (match_a_out && msk_r[0] && $past(msk_r[0])
    |-> irq_out) else $error("unmasked hit gave no irq");
  rd_idle_a: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data outside read slot");
  mask_rd_a: assert property (reg_rd_in && reg_addr_in == 6'h31
    |=> reg_rdata_out == {6'h00, $past(msk_r)}) else $error("mask read");
  ctl_rd_a: assert property (reg_rd_in && reg_addr_in == 6'h29
    |=> reg_rdata_out == $past(c2_r)) else $error("control read");
endmodule : bpc_props
bind bpc_comparators bpc_props bpc_props_inst (.sys_clk_in, .reset_n_in,
  .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .read_cycle_in,
  .bus_valid_in, .reg_rdata_out, .match_a_out, .match_b_out, .irq_out);
`default_nettype wire

// ===== tb/bpc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module bpc_core_model (
  input  wire logic        clk_in,   // core bus clock
  input  wire logic        req_in,   // issue one bus cycle
  input  wire logic [41:0] cyc_in,   // {ab, xab, flash, data, rd}
  output var  logic [41:0] bus_out,  // bus fields
  output var  logic        valid_out // bus cycle present
);
  initial bus_out = 42'h0;
  initial valid_out = 1'b0;
  always @(posedge clk_in) begin
    valid_out <= req_in;
    // idle bus flips, so a stale address can never match by accident
    bus_out <= req_in ? cyc_in : ~bus_out;
  end
endmodule : bpc_core_model
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk_in = 1'b0;
  logic reset_n_in = 1'b1;
  logic [5:0] reg_addr_in = 6'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic req = 1'b0;
  logic [41:0] cyc = 42'h0;
  logic [41:0] bus;
  logic [15:0] core_addr_bus_in, data_bus_in;
  logic [21:14] expanded_addr_bus_in;
  logic flash_access_in, read_cycle_in, bus_valid_in;
  logic [7:0] reg_rdata_out;
  logic match_a_out, match_b_out, irq_out;
  int error_cnt = 0;
  int comparisons = 0;
  assign {core_addr_bus_in, expanded_addr_bus_in, flash_access_in,
          data_bus_in, read_cycle_in} = bus;
  always #4 sys_clk_in = ~sys_clk_in;
  bpc_core_model bpc_core_model_inst (.clk_in(sys_clk_in), .req_in(req),
    .cyc_in(cyc), .bus_out(bus), .valid_out(bus_valid_in));
  bpc_comparators bpc_comparators_inst (.sys_clk_in, .reset_n_in,
    .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .core_addr_bus_in,
    .expanded_addr_bus_in, .flash_access_in, .data_bus_in, .read_cycle_in,
    .bus_valid_in, .reg_rdata_out, .match_a_out, .match_b_out, .irq_out);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_in    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_in   <= 1'b0;
    @(negedge sys_clk_in);
    chk(reg_rdata_out, e);
  endtask : rd
  // one bus cycle {ab, xab, flash, data, rd}; hits land two edges later
  task automatic hit(input logic [41:0] c, input logic [1:0] e);
    @(posedge sys_clk_in);
    cyc <= c;
    req <= 1'b1;
    @(posedge sys_clk_in);
    req <= 1'b0;
    @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    chk({6'h00, match_a_out, match_b_out}, {6'h00, e});
  endtask : hit
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    // a real falling edge, an initialiser alone never fires the async reset
    reset_n_in <= 1'b0;
    repeat (10) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    for (int i = 0; i < 10; i++) rd(6'h28 + i[5:0], 8'h00);
    rd(6'h00, 8'h00);
    $display("reset test done");
    wr(6'h2b, 8'h12);
    wr(6'h2c, 8'h34);
    hit({16'h1234, 8'h00, 1'b0, 16'h0, 1'b1}, 2'b10);
    hit({16'h1235, 8'h00, 1'b0, 16'h0, 1'b1}, 2'b00);
    wr(6'h28, 8'h40);
    hit({16'h12ff, 8'h00, 1'b0, 16'h0, 1'b1}, 2'b10);
    hit({16'h13ff, 8'h00, 1'b0, 16'h0, 1'b1}, 2'b00);
    wr(6'h28, 8'hc0);
    wr(6'h2a, 8'h05);
    hit({16'h8000, 8'h05, 1'b1, 16'h0, 1'b1}, 2'b10);
    hit({16'h8000, 8'h06, 1'b1, 16'h0, 1'b1}, 2'b00);
    wr(6'h28, 8'h00);
    hit({16'hd234, 8'h05, 1'b1, 16'h0, 1'b1}, 2'b10);
    hit({16'h1234, 8'h3a, 1'b0, 16'h0, 1'b1}, 2'b10);
    wr(6'h2e, 8'h56);
    wr(6'h2f, 8'h78);
    wr(6'h28, 8'h03);
    hit({16'h5678, 8'h00, 1'b0, 16'h0, 1'b1}, 2'b01);
    hit({16'h5678, 8'h00, 1'b0, 16'h0, 1'b0}, 2'b00);
    wr(6'h28, 8'h00);
    hit({16'h5678, 8'h00, 1'b0, 16'h0, 1'b0}, 2'b01);
    wr(6'h28, 8'h10);
    hit({16'h56ff, 8'h00, 1'b0, 16'h0, 1'b0}, 2'b01);
    $display("address test done");
    wr(6'h29, 8'h01);
    rd(6'h29, 8'h01);
    wr(6'h28, 8'h03);
    hit({16'h1234, 8'h00, 1'b0, 16'h5678, 1'b0}, 2'b01);
    hit({16'h1234, 8'h00, 1'b0, 16'h5679, 1'b0}, 2'b00);
    hit({16'h1235, 8'h00, 1'b0, 16'h5678, 1'b0}, 2'b00);
    wr(6'h28, 8'h13);
    hit({16'h1234, 8'h00, 1'b0, 16'h56ff, 1'b0}, 2'b01);
    wr(6'h28, 8'h23);
    hit({16'h1234, 8'h00, 1'b0, 16'h0078, 1'b0}, 2'b01);
    wr(6'h28, 8'h33);
    // flash cycle: a page of 05 keeps comparator a whole, b's page is 00
    hit({16'h1234, 8'h05, 1'b1, 16'hffff, 1'b0}, 2'b01);
    wr(6'h28, 8'h03);
    wr(6'h29, 8'h03);
    hit({16'h1234, 8'h00, 1'b0, 16'hffff, 1'b0}, 2'b01);
    $display("full mode test done");
    rd(6'h30, 8'h03);
    chk({7'h00, irq_out}, 8'h00);
    wr(6'h31, 8'h01);
    rd(6'h31, 8'h01);
    chk({7'h00, irq_out}, 8'h01);
    wr(6'h30, 8'h03);
    rd(6'h30, 8'h00);
    chk({7'h00, irq_out}, 8'h00);
    $display("interrupt test done");
    wr(6'h29, 8'h04);
    wr(6'h28, 8'h00);
    wr(6'h2a, 8'h43);
    wr(6'h2b, 8'h85);
    hit({16'h0534, 8'h0e, 1'b0, 16'h0, 1'b1}, 2'b10);
    chk({7'h00, irq_out}, 8'h01);
    wr(6'h2a, 8'hc3);
    hit({16'h0534, 8'h0e, 1'b0, 16'h0, 1'b1}, 2'b10);
    wr(6'h2a, 8'h83);
    hit({16'h0534, 8'h0e, 1'b0, 16'h0, 1'b1}, 2'b00);
    $display("trace mode test done");
    stop_test();
  end
endmodule : testbench
`default_nettype wire
